// File: eri_pkg.sv
// constants shared by the four-channel e1 receive line input stage
package eri_pkg;
    localparam int NUM_CH = 4;

    // register map, byte addresses on the ahb-lite slave
    localparam logic [7:0] CFG0_OFFSET   = 8'h00;  // cfg of channel n at 4*n
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [2:0] REG_IDX_STATUS = 3'h4;
    localparam logic [2:0] REG_IDX_NONE   = 3'h7;

    // per-channel configuration fields
    localparam int CFG_DUAL_RAIL   = 0;  // 1 dual rail, 0 single rail
    localparam int CFG_RZ          = 1;  // dual rail only: 1 rz, 0 nrz
    localparam int CFG_FALL_EDGE   = 2;  // 1 sample on falling line clock
    localparam int CFG_SMOOTH_CLK  = 3;  // 1 smoothed clock drives out
    localparam int CFG_OUT_CLK_SEL = 4;  // out_clk_select_bit
    localparam int CFG_SLIP_BYPASS = 5;  // rx_slip_buffer bypassed
    localparam int CFG_W           = 6;
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

    // status nibble per channel, channel n at bits 4n+3:4n
    localparam int ST_CLK = 0;
    localparam int ST_POS = 1;
    localparam int ST_NEG = 2;
    localparam int ST_CV  = 3;
    localparam int ST_W   = 4;

    // raw input bundle positions inside each channel's synchroniser
    localparam int IN_POS    = 0;
    localparam int IN_NEG    = 1;
    localparam int IN_SINGLE = 2;
    localparam int IN_CV     = 3;
    localparam int IN_LCLK   = 4;
    localparam int IN_SMOOTH = 5;
    localparam int IN_W      = 6;

    // timing: rz clock recovery by a phase accumulator at the line rate
    localparam longint MASTER_CLK_HZ = 64'd20000000;
    localparam longint LINE_CLK_HZ   = 64'd2048000;
    localparam int     PHASE_W       = 16;
    localparam logic [PHASE_W-1:0] PHASE_INC = PHASE_W'(
        ((LINE_CLK_HZ << PHASE_W) + MASTER_CLK_HZ / 2) / MASTER_CLK_HZ);
    localparam logic [PHASE_W-1:0] PHASE_RESYNC = 16'h0000;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;
endpackage : eri_pkg

// File: eri_line_input.sv
// four-channel e1 receive line input stage with ahb-lite config registers
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
module eri_line_input (
    input  wire logic        hclk,                  // master_clk, 20 MHz
    input  wire logic        hresetn,               // async reset, low
    input  wire logic        hsel,                  // slave select
    input  wire logic [31:0] haddr,                 // byte address
    input  wire logic [1:0]  htrans,                // transfer type
    input  wire logic        hwrite,                // 1 write
    input  wire logic [2:0]  hsize,                 // word only
    input  wire logic [31:0] hwdata,                // write data
    input  wire logic        hready,                // bus ready
    output logic      [31:0] hrdata,                // read data
    output logic             hreadyout,             // low in reset, high from the first clock after
    output logic             hresp,                 // always okay
    input  wire logic [3:0]  rx_pos_rail_in,        // positive rail
    input  wire logic [3:0]  rx_neg_rail_in,        // negative rail
    input  wire logic [3:0]  rx_single_rail_in,     // single-rail data
    input  wire logic [3:0]  rx_code_violation_in,  // external cv flag
    input  wire logic [3:0]  rx_line_clk_in,        // line clock
    input  wire logic [3:0]  jat_smooth_clk_in,     // smoothed clock
    input  wire logic [3:0]  bp_pcm_in,             // pcm to backplane
    input  wire logic [3:0]  bp_sig_in,             // signaling to bp
    output logic      [3:0]  rx_recovered_clk_out,  // recovered clock
    output logic      [3:0]  rx_pos_data_out,       // decoded pos/data
    output logic      [3:0]  rx_neg_data_out,       // decoded neg
    output logic      [3:0]  rx_cv_out,             // code violation
    output logic      [3:0]  rx_bit_strobe_out,     // bit valid pulse
    output logic      [3:0]  backplane_rx_pcm_out,  // backplane pcm
    output logic      [3:0]  backplane_rx_sig_out   // backplane sig
);

    // maps a byte address to a register index, unmapped otherwise
    function automatic logic [2:0] reg_index(input logic [31:0] a);
        logic [2:0] idx;
        idx = eri_pkg::REG_IDX_NONE;
        if (a[31:5] == 27'h0000000 && a[1:0] == 2'h0) begin
            if (a[7:0] == eri_pkg::STATUS_OFFSET) begin
                idx = eri_pkg::REG_IDX_STATUS;
            end else if (a[4] == 1'b0) begin
                idx = {1'b0, a[3:2]};
            end
        end
        return idx;
    endfunction : reg_index

    // bus slave: zero wait states, every response okay
    logic                           wr_pend_q;
    logic                           wr_pend_d;
    logic [2:0]                     wr_idx_q;
    logic [2:0]                     wr_idx_d;
    logic [31:0]                    hrdata_d;
    logic                           hreadyout_q;
    logic [eri_pkg::CFG_W-1:0]      cfg_q [eri_pkg::NUM_CH];
    logic [eri_pkg::CFG_W-1:0]      cfg_d [eri_pkg::NUM_CH];
    logic [eri_pkg::NUM_CH*eri_pkg::ST_W-1:0] status_w;
    logic                           addr_ok;
    logic [2:0]                     rd_idx;

    always_comb begin
        addr_ok   = hsel && hready && (htrans == eri_pkg::HTRANS_NONSEQ);
        rd_idx    = reg_index(haddr);
        wr_pend_d = addr_ok && hwrite;
        wr_idx_d  = wr_pend_d ? rd_idx : wr_idx_q;
        for (int c = 0; c < eri_pkg::NUM_CH; c++) begin
            cfg_d[c] = cfg_q[c];
            // each channel's word is written only by its own address
            if (wr_pend_q && wr_idx_q == 3'(c)) begin
                cfg_d[c] = hwdata[eri_pkg::CFG_W-1:0];
            end
        end
        hrdata_d = 32'h00000000;
        // read uses next cfg, so a read right after a write sees it
        if (addr_ok && !hwrite) begin
            if (rd_idx == eri_pkg::REG_IDX_STATUS) begin
                hrdata_d = 32'(status_w);
            end else if (rd_idx != eri_pkg::REG_IDX_NONE) begin
                hrdata_d = 32'(cfg_d[rd_idx[1:0]]);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q   <= 1'b0;
            wr_idx_q    <= eri_pkg::REG_IDX_NONE;
            hrdata      <= 32'h00000000;
            hreadyout_q <= 1'b0;
            hresp       <= eri_pkg::HRESP_OKAY;
            for (int c = 0; c < eri_pkg::NUM_CH; c++) begin
                cfg_q[c] <= eri_pkg::CFG_RESET;
            end
        end else begin
            wr_pend_q   <= wr_pend_d;
            wr_idx_q    <= wr_idx_d;
            hrdata      <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp       <= eri_pkg::HRESP_OKAY;
            cfg_q       <= cfg_d;
        end
    end

    assign hreadyout = hreadyout_q;

    // per-channel line input: two-stage sync, then edge and cell logic
    for (genvar ch = 0; ch < eri_pkg::NUM_CH; ch++) begin : g_ch
        logic [eri_pkg::IN_W-1:0]    raw;
        logic [eri_pkg::IN_W-1:0]    s1_q;
        logic [eri_pkg::IN_W-1:0]    s2_q;
        logic [eri_pkg::IN_W-1:0]    s3_q;
        logic [eri_pkg::PHASE_W-1:0] phase_q;
        logic [eri_pkg::PHASE_W-1:0] phase_d;
        logic [eri_pkg::PHASE_W:0]   phase_sum;
        logic                        seen_pos_q;
        logic                        seen_pos_d;
        logic                        seen_neg_q;
        logic                        seen_neg_d;
        logic                        rclk_q;
        logic                        rclk_d;
        logic                        pos_q;
        logic                        pos_d;
        logic                        neg_q;
        logic                        neg_d;
        logic                        cv_q;
        logic                        cv_d;
        logic                        strobe_q;
        logic                        strobe_d;
        logic                        pcm_q;
        logic                        pcm_d;
        logic                        sig_q;
        logic                        sig_d;
        logic                        dual;
        logic                        rz;
        logic                        lclk_rise;
        logic                        lclk_fall;
        logic                        edge_hit;
        logic                        pulse_now;
        logic                        pulse_rise;
        logic                        bit_end;
        logic                        line_clk;
        logic                        pace;
        logic                        rclk_fall;

        assign raw = {jat_smooth_clk_in[ch], rx_line_clk_in[ch],
                      rx_code_violation_in[ch], rx_single_rail_in[ch],
                      rx_neg_rail_in[ch], rx_pos_rail_in[ch]};

        always_comb begin
            dual      = cfg_q[ch][eri_pkg::CFG_DUAL_RAIL];
            rz        = dual && cfg_q[ch][eri_pkg::CFG_RZ];
            lclk_rise = s2_q[eri_pkg::IN_LCLK] && !s3_q[eri_pkg::IN_LCLK];
            lclk_fall = !s2_q[eri_pkg::IN_LCLK] && s3_q[eri_pkg::IN_LCLK];
            // sampling edge is chosen per channel
            edge_hit  = cfg_q[ch][eri_pkg::CFG_FALL_EDGE] ? lclk_fall
                                                          : lclk_rise;
            // a mode switch can line up two bit ends; keep strobes apart
            edge_hit  = edge_hit && !strobe_q;
            // any mark on either rail starts a bit cell
            pulse_now  = s2_q[eri_pkg::IN_POS] || s2_q[eri_pkg::IN_NEG];
            pulse_rise = pulse_now &&
                         !(s3_q[eri_pkg::IN_POS] || s3_q[eri_pkg::IN_NEG]);
            phase_sum  = {1'b0, phase_q} + {1'b0, eri_pkg::PHASE_INC};
            // a late pulse closes the cell early so no bit is dropped
            bit_end    = phase_sum[eri_pkg::PHASE_W] ||
                         (pulse_rise && phase_q[eri_pkg::PHASE_W-1]);
            // within rz two cell ends never touch, so this only bites
            // on the cycle a mode change lands
            bit_end    = bit_end && !strobe_q;
            phase_d    = pulse_rise ? eri_pkg::PHASE_RESYNC
                                    : phase_sum[eri_pkg::PHASE_W-1:0];
            seen_pos_d = seen_pos_q;
            seen_neg_d = seen_neg_q;
            pos_d      = pos_q;
            neg_d      = neg_q;
            cv_d       = 1'b0;
            strobe_d   = 1'b0;
            if (rz) begin
                // rz ignores the line clock: rails hold both clock and data
                strobe_d   = bit_end;
                if (bit_end) begin
                    pos_d      = seen_pos_q;
                    neg_d      = seen_neg_q;
                    seen_pos_d = s2_q[eri_pkg::IN_POS];
                    seen_neg_d = s2_q[eri_pkg::IN_NEG];
                end else begin
                    seen_pos_d = seen_pos_q || s2_q[eri_pkg::IN_POS];
                    seen_neg_d = seen_neg_q || s2_q[eri_pkg::IN_NEG];
                end
            end else if (dual) begin
                // nrz relies on the line interface supplying the clock
                strobe_d = edge_hit;
                if (edge_hit) begin
                    pos_d = s2_q[eri_pkg::IN_POS];
                    neg_d = s2_q[eri_pkg::IN_NEG];
                end
            end else begin
                strobe_d = edge_hit;
                // neg clears with the first single-rail bit, not before,
                // so decoded bits only ever move with a strobe
                if (edge_hit) begin
                    neg_d = 1'b0;
                    pos_d = s2_q[eri_pkg::IN_SINGLE];
                    cv_d  = s2_q[eri_pkg::IN_CV];
                end
            end
            // rz: high during the first half of the recovered cell
            line_clk = rz ? !phase_q[eri_pkg::PHASE_W-1]
                          : s2_q[eri_pkg::IN_LCLK];
            rclk_d   = cfg_q[ch][eri_pkg::CFG_SMOOTH_CLK]
                       ? s2_q[eri_pkg::IN_SMOOTH] : line_clk;
            rclk_fall = rclk_q && !rclk_d;
            pace      = cfg_q[ch][eri_pkg::CFG_SLIP_BYPASS] ||
                        cfg_q[ch][eri_pkg::CFG_OUT_CLK_SEL];
            pcm_d     = bp_pcm_in[ch];
            sig_d     = bp_sig_in[ch];
            // paced mode holds the outputs between falling clock edges
            if (pace && !rclk_fall) begin
                pcm_d = pcm_q;
                sig_d = sig_q;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                s1_q       <= '0;
                s2_q       <= '0;
                s3_q       <= '0;
                phase_q    <= '0;
                seen_pos_q <= 1'b0;
                seen_neg_q <= 1'b0;
                rclk_q     <= 1'b0;
                pos_q      <= 1'b0;
                neg_q      <= 1'b0;
                cv_q       <= 1'b0;
                strobe_q   <= 1'b0;
                pcm_q      <= 1'b0;
                sig_q      <= 1'b0;
            end else begin
                s1_q       <= raw;
                s2_q       <= s1_q;
                s3_q       <= s2_q;
                phase_q    <= phase_d;
                seen_pos_q <= seen_pos_d;
                seen_neg_q <= seen_neg_d;
                rclk_q     <= rclk_d;
                pos_q      <= pos_d;
                neg_q      <= neg_d;
                cv_q       <= cv_d;
                strobe_q   <= strobe_d;
                pcm_q      <= pcm_d;
                sig_q      <= sig_d;
            end
        end

        assign rx_recovered_clk_out[ch] = rclk_q;
        assign rx_pos_data_out[ch]      = pos_q;
        assign rx_neg_data_out[ch]      = neg_q;
        assign rx_cv_out[ch]            = cv_q;
        assign rx_bit_strobe_out[ch]    = strobe_q;
        assign backplane_rx_pcm_out[ch] = pcm_q;
        assign backplane_rx_sig_out[ch] = sig_q;
        assign status_w[ch*eri_pkg::ST_W +: eri_pkg::ST_W] =
            {cv_q, neg_q, pos_q, rclk_q};
    end

endmodule : eri_line_input

// File: eri_line_input_asserts.sv
// assertion checker for the e1 receive line input stage
module eri_line_input_asserts (
    input wire logic        hclk,                  // master clock
    input wire logic        hresetn,               // reset, low
    input wire logic        hsel,                  // slave select
    input wire logic [31:0] haddr,                 // byte address
    input wire logic [1:0]  htrans,                // transfer type
    input wire logic        hwrite,                // write
    input wire logic [31:0] hwdata,                // write data
    input wire logic        hready,                // bus ready
    input wire logic [3:0]  rx_line_clk_in,        // line clock
    input wire logic [3:0]  bp_pcm_in,             // pcm source
    input wire logic [3:0]  bp_sig_in,             // sig source
    input wire logic [3:0]  rx_recovered_clk_out,  // clock out
    input wire logic [3:0]  rx_pos_data_out,       // pos bit
    input wire logic [3:0]  rx_neg_data_out,       // neg bit
    input wire logic [3:0]  rx_cv_out,             // violation
    input wire logic [3:0]  rx_bit_strobe_out,     // bit strobe
    input wire logic [3:0]  backplane_rx_pcm_out,  // pcm out
    input wire logic [3:0]  backplane_rx_sig_out   // sig out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // shadow of the cfg words, so mode-dependent rules can be judged
    logic            wr_q;
    logic [1:0]      ch_q;
    logic [3:0][5:0] cfg_q;
    logic [3:0]      pv;
    logic [3:0]      lk;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q  <= 1'b0;
            ch_q  <= 2'h0;
            cfg_q <= '0;
        end else begin
            wr_q  <= hsel && hready && htrans == eri_pkg::HTRANS_NONSEQ
                     && hwrite && haddr < 32'h10 && haddr[1:0] == 2'h0;
            ch_q  <= haddr[3:2];
            if (wr_q)
                cfg_q[ch_q] <= hwdata[5:0];
        end
    end
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            pv[c] = cfg_q[c][4] | cfg_q[c][5];
            lk[c] = !(cfg_q[c][0] & cfg_q[c][1]) & !cfg_q[c][3];
        end
    end

    property p_cv;
        (rx_cv_out & ~rx_bit_strobe_out) == 4'h0;
    endproperty
    a_cv: assert property (p_cv)
        else $error("violation flag without strobe");
    property p_pulse;
        (rx_bit_strobe_out & $past(rx_bit_strobe_out)) == 4'h0;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("strobe longer than one cycle");
    property p_hold;
        (((rx_pos_data_out ^ $past(rx_pos_data_out)) | (rx_neg_data_out
            ^ $past(rx_neg_data_out))) & ~rx_bit_strobe_out) == 4'h0;
    endproperty
    a_hold: assert property (p_hold)
        else $error("decoded bit moved between strobes");
    property p_clk_line;
        $past(hresetn, 4) |-> ((rx_recovered_clk_out
            ^ $past(rx_line_clk_in, 3)) & $past(lk) & $past(lk, 4)) == 4'h0;
    endproperty
    a_clk_line: assert property (p_clk_line)
        else $error("clock out does not follow line clock");
    property p_bp_follow;
        $past(hresetn) |-> ((backplane_rx_pcm_out ^ $past(bp_pcm_in))
            & ~$past(pv)) == 4'h0;
    endproperty
    a_bp_follow: assert property (p_bp_follow)
        else $error("unpaced pcm not one cycle behind");
    property p_bp_hold;
        ((backplane_rx_pcm_out ^ $past(backplane_rx_pcm_out)) & $past(pv)
            & ~($past(rx_recovered_clk_out) & ~rx_recovered_clk_out)) == 0;
    endproperty
    a_bp_hold: assert property (p_bp_hold)
        else $error("paced pcm moved off the falling clock");
    property p_bp_load;
        ((backplane_rx_pcm_out ^ $past(bp_pcm_in)) & $past(pv)
            & $past(rx_recovered_clk_out) & ~rx_recovered_clk_out) == 0;
    endproperty
    a_bp_load: assert property (p_bp_load)
        else $error("paced pcm not loaded at falling clock");
    property p_sig_load;
        ((backplane_rx_sig_out ^ $past(bp_sig_in)) & $past(pv)
            & $past(rx_recovered_clk_out) & ~rx_recovered_clk_out) == 0;
    endproperty
    a_sig_load: assert property (p_sig_load)
        else $error("paced sig not loaded at falling clock");
    c_strobe: cover property (|rx_bit_strobe_out);
    c_cv: cover property (|rx_cv_out);
    c_paced: cover property (|($past(pv) & $past(rx_recovered_clk_out)
        & ~rx_recovered_clk_out));
endmodule : eri_line_input_asserts

// File: eri_line_model.sv
// line interface model: one e1 channel feeding nrz or rz rails
module eri_line_model #(
    parameter int SEED = 1
) (
    input  wire logic       rz,    // send rz rails, hold line clock
    input  wire logic       fall,  // receiver samples falling edge
    output logic            lclk,  // 2.048 MHz line clock
    output logic            pos,   // positive rail
    output logic            neg,   // negative rail
    output logic            sd,    // single-rail data
    output logic            cv,    // violation flag
    output logic      [3:0] smp    // pos, neg, sd, cv at sampling
);
    timeunit 1ns;
    timeprecision 1ps;
    int         s  = SEED;
    logic [3:0] nx;
    logic       mk = 1'b0;
    always begin
        nx = 4'($random(s));
        if (rz) begin
            // ami marks as half-width pulses; line clock stands low
            lclk = 1'b0;
            mk = mk ^ nx[0];
            {pos, neg, sd, cv} = {nx[0] & mk, nx[0] & !mk, 2'b00};
            #244.141;
            {pos, neg} = 2'b00;
            #244.141;
        end else begin
            // launch opposite the sampling edge so data sits mid-bit
            lclk = fall;
            {pos, neg, sd, cv} = {nx[3], nx[2] & !nx[3], nx[1:0]};
            #244.141;
            lclk = !fall;
            smp = {pos, neg, sd, cv};
            #244.141;
        end
    end
endmodule : eri_line_model

// File: tb_top.sv
// testbench for the e1 receive line input stage
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, d;
    logic [15:0] st_w;
    logic        hreadyout, hresp, chk = 1'b0;
    logic [3:0]  bp_pcm = 4'h0, bp_sig = 4'h0, scnt = 4'h0, prv = 4'h0;
    logic [3:0]  clk_o, pos_o, neg_o, cv_o, stb, bpp_o, bps_o;
    wire  [3:0]  lclk, pos, neg, sd, cv;
    wire  [3:0]  smp [4];
    logic [5:0]  cfg [4] = '{default: 6'h00};
    logic [1:0]  m;
    int          seed = 32'h271f;
    int          fail_count = 0;
    int          tests_run = 0;
    int          nstb [4], nrise [4];
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        bp_pcm <= 4'($random(seed));
        bp_sig <= 4'($random(seed));
        scnt   <= scnt + 4'h1;
    end
    eri_line_input u_eri_line_input (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_pos_rail_in(pos),
        .rx_neg_rail_in(neg), .rx_single_rail_in(sd),
        .rx_code_violation_in(cv), .rx_line_clk_in(lclk),
        .jat_smooth_clk_in({4{scnt[3]}}), .bp_pcm_in(bp_pcm),
        .bp_sig_in(bp_sig), .rx_recovered_clk_out(clk_o),
        .rx_pos_data_out(pos_o), .rx_neg_data_out(neg_o), .rx_cv_out(cv_o),
        .rx_bit_strobe_out(stb), .backplane_rx_pcm_out(bpp_o),
        .backplane_rx_sig_out(bps_o));
    for (genvar c = 0; c < 4; c++) begin : g_line
        eri_line_model #(.SEED(c + 11)) u_eri_line_model (
            .rz(cfg[c][0] & cfg[c][1]), .fall(cfg[c][2]), .lclk(lclk[c]),
            .pos(pos[c]), .neg(neg[c]), .sd(sd[c]), .cv(cv[c]),
            .smp(smp[c]));
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic xfer(input logic wr, input logic [31:0] a, wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= eri_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        // outputs still show what a status read latches at this edge
        for (int c = 0; c < 4; c++)
            st_w[c*4 +: 4] = {cv_o[c], neg_o[c], pos_o[c], clk_o[c]};
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'(eri_pkg::HRESP_OKAY));
        hsel <= 1'b0;
    endtask : xfer
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // bit and clock counts over a 20 us window, about 41 line bits
    task automatic phase();
        #2010;
        nstb = '{default: 0};
        nrise = '{default: 0};
        chk = 1'b1;
        #20000;
        chk = 1'b0;
        for (int c = 0; c < 4; c++) begin
            if (cfg[c][3])
                check(32'(nrise[c] inside {[24:26]}), 32'h1);
            else if (cfg[c][1]) begin
                check(32'(nrise[c] inside {[38:44]}), 32'h1);
                check(32'(nstb[c] inside {[38:44]}), 32'h1);
            end else begin
                check(32'(nstb[c] inside {[39:43]}), 32'h1);
                check(32'(nrise[c] inside {[39:43]}), 32'h1);
            end
        end
    endtask : phase
    always @(posedge hclk) begin
        prv <= clk_o;
        for (int c = 0; c < 4; c++) begin
            if (chk && clk_o[c] === 1'b1 && prv[c] === 1'b0)
                nrise[c]++;
            if (chk && stb[c] === 1'b1)
                nstb[c]++;
            if (chk && stb[c] === 1'b1 && !cfg[c][1]) begin
                if (cfg[c][0]) begin
                    check(pos_o[c], smp[c][3]);
                    check(neg_o[c], smp[c][2]);
                    check(cv_o[c], 1'b0);
                end else begin
                    check(pos_o[c], smp[c][1]);
                    check(neg_o[c], 1'b0);
                    check(cv_o[c], smp[c][0]);
                end
            end
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int a = 0; a < 4; a++) begin
            xfer(1'b0, 32'(a * 4), 32'h0, d);
            check(d, 32'h0);
        end
        xfer(1'b1, 32'h20, 32'hFFFFFFFF, d);
        xfer(1'b0, 32'h20, 32'h0, d);
        check(d, 32'h0);
        // four nrz formats rotated over channels, then rz against smoothed
        for (int k = 0; k < 6; k++) begin
            for (int c = 0; c < 4; c++) begin
                d = $random(seed);
                m = 2'(c + k);
                d[3:0] = k < 4 ? {1'b0, m[0], 1'b0, m[1]}
                               : (m[0] ? 4'h8 : 4'h3);
                // select bit left random: no frame pulse is relied on
                cfg[c] = d[5:0];
                xfer(1'b1, 32'(c * 4), d, d);
            end
            for (int c = 0; c < 4; c++) begin
                xfer(1'b0, 32'(c * 4), 32'h0, d);
                check(d, {26'h0, cfg[c]});
            end
            phase();
            xfer(1'b0, 32'h10, 32'h0, d);
            check(d, {16'h0, st_w});
        end
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        xfer(1'b0, 32'h4, 32'h0, d);
        check(d, 32'h0);
        end_sim();
    end
    // six windows of about 22 us plus bus traffic fit well inside this
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end
endmodule : tb_top
bind eri_line_input eri_line_input_asserts u_eri_line_input_asserts (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .rx_line_clk_in, .bp_pcm_in, .bp_sig_in, .rx_recovered_clk_out,
    .rx_pos_data_out, .rx_neg_data_out, .rx_cv_out, .rx_bit_strobe_out,
    .backplane_rx_pcm_out, .backplane_rx_sig_out);
